/* rtl/fpw_defines.svh */
// Summary of operation
// - deep power-down ignores all but wake opcode
// - wake is opcode ABh; trailing whole bytes ignored
// - wake on select release, then standby
// - wake-to-standby latency at most 30 us
// - short or unaligned wake frame is abandoned
// - pause never stalls internal program/erase
// - pause entered only while selected
// - pause starts when asserted in clock low
// - pause asserted in clock high deferred
// - pause holds while pause and select asserted
// - data output high impedance while paused
// - clock and data input ignored while paused
// - write protect still followed while paused
// - pause release in clock high deferred
// - select release during pause aborts, clears latch
// - drive on falling edge, sample on rising
`ifndef FPW_DEFINES_SVH
`define FPW_DEFINES_SVH
`define FPW_OP_WAKE        8'hAB
`define FPW_OP_SLEEP       8'hB9
`define FPW_OP_WREN        8'h06
`define FPW_OP_WRDI        8'h04
`define FPW_CLK_PERIOD_NS  100
`define FPW_WAKE_TIME_US   30
`define FPW_WAKE_CYCLES    ((`FPW_WAKE_TIME_US * 1000) / `FPW_CLK_PERIOD_NS)
`define FPW_CNT_W          9
`endif

/* rtl/fpw_pkg.sv */
package fpw_pkg;
    typedef enum logic [2:0] {
        FPW_STANDBY = 3'h1,
        FPW_SLEEP   = 3'h2,
        FPW_WAKING  = 3'h4
    } fpw_pwr_t;
    typedef logic [7:0] fpw_byte_t;
endpackage

/* rtl/fpw_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser per bit; first stage read only by second
module fpw_sync #(
    parameter int           W       = 5,
    parameter logic [W-1:0] RST_VAL = {W{1'b1}}
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // reset to the pin's idle level, so no false edge follows reset
            always_ff @(posedge ref_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_q[g] <= RST_VAL[g];
                    q_o[g]    <= RST_VAL[g];
                end else begin
                    meta_q[g] <= d_i[g];
                    q_o[g]    <= meta_q[g];
                end
            end
        end
    endgenerate
endmodule // fpw_sync

/* rtl/fpw_ctrl.sv */
`timescale 1ns/1ps
`include "fpw_defines.svh"
module fpw_ctrl
    import fpw_pkg::*;
#(
    parameter int WAKE_CYCLES = `FPW_WAKE_CYCLES
) (
    // system
    input  wire logic  ref_clk_i,
    input  wire logic  rstn_i,
    // serial pins
    input  wire logic  cs_n_i,
    input  wire logic  sck_i,
    input  wire logic  si_i,
    input  wire logic  pause_n_i,
    input  wire logic  wp_n_i,
    output logic       so_o,
    output logic       so_oe_o,
    // core side
    input  wire logic  so_data_i,
    input  wire logic  busy_i,
    output logic       standby_o,
    output logic       paused_o,
    output logic       write_enable_latch_o,
    output logic       wp_active_o,
    output logic       busy_o,
    output logic       abort_o,
    output logic       byte_valid_o,
    output logic [7:0] byte_o
);
    import fpw_pkg::*;

    logic [4:0] raw;
    logic [4:0] syn;
    logic       cs_n_s, sck_s, si_s, pause_n_s, wp_n_s;
    logic       sck_prev_q, cs_prev_q;
    logic       rise, fall, cs_rel;
    fpw_pwr_t   pwr_q;
    logic [2:0] bit_cnt_q;
    logic       first_q;
    logic [7:0] sh_q;
    logic [7:0] op_q;
    logic       wake_ok_q;
    logic [`FPW_CNT_W-1:0] wake_cnt_q;

    assign raw = {wp_n_i, pause_n_i, si_i, sck_i, cs_n_i};

    // pins cross into the reference clock domain
    // serial clock idles low, the active-low pins idle high
    fpw_sync #(.W(5), .RST_VAL(5'h1D)) u_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .d_i       (raw),
        .q_o       (syn)
    );
    assign {wp_n_s, pause_n_s, si_s, sck_s, cs_n_s} = syn;

    // edge history of the synchronised clock and select
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q  <= cs_n_s;
        end
    end

    // edges count only when selected and not paused
    assign rise   = sck_s & ~sck_prev_q & ~cs_n_s & ~paused_o;
    assign fall   = ~sck_s & sck_prev_q & ~cs_n_s & ~paused_o;
    assign cs_rel = cs_n_s & ~cs_prev_q;

    // pause state changes only while clock is low, or clears on deselect
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            paused_o <= 1'b0;
        end else if (cs_n_s) begin
            paused_o <= 1'b0;
        end else if (!sck_s) begin
            paused_o <= ~pause_n_s;
        end // high phase keeps state
    end

    // input shifter samples on rising clock edge
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_q         <= 8'h00;
            bit_cnt_q    <= 3'h0;
            first_q      <= 1'b1;
            op_q         <= 8'h00;
            byte_valid_o <= 1'b0;
            byte_o       <= 8'h00;
        end else begin
            byte_valid_o <= 1'b0;
            if (cs_n_s) begin
                bit_cnt_q <= 3'h0;
                first_q   <= 1'b1;
            end else if (rise) begin
                sh_q      <= {sh_q[6:0], si_s};
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7) begin
                    first_q <= 1'b0;
                    if (first_q) begin
                        op_q <= {sh_q[6:0], si_s};
                    end
                    if (pwr_q == FPW_STANDBY) begin
                        byte_valid_o <= 1'b1;
                        byte_o       <= {sh_q[6:0], si_s};
                    end
                end
            end
        end
    end

    // wake opcode seen as first byte of frame; later bits ignored
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_ok_q <= 1'b0;
        end else if (cs_n_s) begin
            wake_ok_q <= 1'b0;
        end else if (rise && bit_cnt_q == 3'h7 && first_q) begin
            wake_ok_q <= ({sh_q[6:0], si_s} == `FPW_OP_WAKE);
        end
    end

    // power state machine
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwr_q      <= FPW_STANDBY;
            wake_cnt_q <= '0;
        end else begin
            case (pwr_q)
                FPW_STANDBY: begin
                    if (cs_rel && !first_q && bit_cnt_q == 3'h0
                        && op_q == `FPW_OP_SLEEP && !busy_i) begin
                        pwr_q <= FPW_SLEEP;
                    end
                end
                FPW_SLEEP: begin
                    // short or unaligned frame leaves it asleep
                    if (cs_rel && wake_ok_q && bit_cnt_q == 3'h0) begin
                        pwr_q      <= FPW_WAKING;
                        wake_cnt_q <= '0;
                    end
                end
                FPW_WAKING: begin
                    // fixed count, by default equal to the latency bound
                    if (wake_cnt_q >= `FPW_CNT_W'(WAKE_CYCLES - 1)) begin
                        pwr_q <= FPW_STANDBY;
                    end else begin
                        wake_cnt_q <= wake_cnt_q + 1'b1;
                    end
                end
                default: pwr_q <= FPW_STANDBY;
            endcase
        end
    end

    // write enable latch; pause abort clears it
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            write_enable_latch_o <= 1'b0;
            abort_o              <= 1'b0;
        end else begin
            abort_o <= 1'b0;
            if (cs_rel && paused_o) begin
                write_enable_latch_o <= 1'b0;
                abort_o              <= 1'b1;
            end else if (cs_rel && pwr_q == FPW_STANDBY && !first_q
                         && bit_cnt_q == 3'h0) begin
                if (op_q == `FPW_OP_WREN) write_enable_latch_o <= 1'b1;
                if (op_q == `FPW_OP_WRDI) write_enable_latch_o <= 1'b0;
            end
        end
    end

    // output driven on falling edge, released while paused
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            so_o    <= 1'b0;
            so_oe_o <= 1'b0;
        end else begin
            if (fall) begin
                so_o <= so_data_i;
            end
            // a deferred pause keeps driving until the pause really begins
            so_oe_o <= ~cs_n_s & ~paused_o & (pwr_q == FPW_STANDBY);
        end
    end

    // status flags; busy passes regardless of pause
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            standby_o   <= 1'b1;
            wp_active_o <= 1'b0;
            busy_o      <= 1'b0;
        end else begin
            standby_o   <= (pwr_q == FPW_STANDBY);
            wp_active_o <= ~wp_n_s;
            busy_o      <= busy_i;
        end
    end

    // a short or unaligned frame in sleep must leave the state alone
    property p_short_wake;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            (pwr_q == FPW_SLEEP && cs_rel && bit_cnt_q != 3'h0) |=> (pwr_q == FPW_SLEEP);
    endproperty
    a_short_wake : assert property (p_short_wake) else $error("unaligned wake accepted");

    property p_pause_needs_cs;
        @(posedge ref_clk_i) disable iff (!rstn_i) paused_o |-> !$past(cs_n_s);
    endproperty
    a_pause_needs_cs : assert property (p_pause_needs_cs) else $error("pause without select");
    property p_pause_low;
        @(posedge ref_clk_i) disable iff (!rstn_i) $rose(paused_o) |-> !$past(sck_s);
    endproperty
    a_pause_low : assert property (p_pause_low) else $error("pause began in high");
    property p_pause_hold_high;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            ($past(sck_s) && !$past(cs_n_s)) |-> $stable(paused_o);
    endproperty
    a_pause_hold_high : assert property (p_pause_hold_high) else $error("pause moved in high");
    property p_pause_so;
        @(posedge ref_clk_i) disable iff (!rstn_i) paused_o |=> !so_oe_o;
    endproperty
    a_pause_so : assert property (p_pause_so) else $error("output on while paused");
    property p_no_shift;
        @(posedge ref_clk_i) disable iff (!rstn_i) paused_o |=> $stable(sh_q);
    endproperty
    a_no_shift : assert property (p_no_shift) else $error("shift while paused");
    property p_abort;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            (cs_rel && paused_o) |=> (abort_o && !write_enable_latch_o);
    endproperty
    a_abort : assert property (p_abort) else $error("pause abort missed");
    // latency limit in reference clocks, independent of the chosen count
    localparam int WAKE_BOUND = `FPW_WAKE_CYCLES;
    sequence s_woken;
        pwr_q == FPW_STANDBY;
    endsequence
    property p_wake_bound;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            $rose(pwr_q == FPW_WAKING) |-> ##[1:WAKE_BOUND] s_woken;
    endproperty
    a_wake_bound : assert property (p_wake_bound) else $error("wake too slow");
    property p_sleep_quiet;
        @(posedge ref_clk_i) disable iff (!rstn_i) (pwr_q != FPW_STANDBY) |=> !byte_valid_o;
    endproperty
    a_sleep_quiet : assert property (p_sleep_quiet) else $error("byte while asleep");
endmodule // fpw_ctrl

/* bench/fpw_host.sv */
`timescale 1ns/1ps
// serial bus master standing in for the host controller
module fpw_host (
    // clock
    input  wire logic ref_clk_i,
    // pins toward the device
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    output logic      pause_n_o,
    output logic      wp_n_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    localparam int HALF = 4; // 400 ns high phase, 500 ns low phase, 900 ns link clock
    logic so_cap_q;
    // idle: deselected, clock parked low
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        pause_n_o = 1'b1;
        wp_n_o = 1'b1;
        so_cap_q = 1'b0;
    end
    // k: 0 select, 1 pause, 2 write protect, else clock
    task automatic pin(input int k, input logic v);
        @(negedge ref_clk_i);
        case (k)
            0: cs_n_o = v;
            1: pause_n_o = v;
            2: wp_n_o = v;
            default: sck_o = v;
        endcase
        if (k == 0 && v) si_o = ~si_o; // released data is not left at its last value
    endtask
    // msb first; full=0 is mode 0, full=1 launches each bit after the first just after a rise
    task automatic send(input logic [15:0] d, input int n, input logic full);
        @(negedge ref_clk_i);
        si_o = d[n-1];
        for (int i = n - 1; i >= 0; i--) begin
            repeat (HALF) @(negedge ref_clk_i);
            sck_o = 1'b1;
            if (!full) so_cap_q = so_oe_i ? so_i : so_cap_q;
            @(negedge ref_clk_i);
            if (full && i > 0) si_o = d[i-1];
            repeat (HALF - 1) @(negedge ref_clk_i);
            sck_o = 1'b0;
            if (full) so_cap_q = so_oe_i ? so_i : so_cap_q;
            @(negedge ref_clk_i);
            if (!full && i > 0) si_o = d[i-1];
        end
    endtask
endmodule // fpw_host

/* bench/flash_serial_pause_wake_ctrl_bench.sv */
`timescale 1ns/1ps
module flash_serial_pause_wake_ctrl_bench;
    import fpw_pkg::*;
    localparam int WAKE = 4; // shortened wake count keeps the run brief
    logic       ref_clk_i;
    logic       rstn_i;
    logic       cs_n, sck, si, pause_n, wp_n, so, so_oe, busy;
    logic       standby, paused, write_enable_latch, wp_act, busy_o, abort, bv;
    logic [7:0] byte_o;
    logic [7:0] last = 8'h00;
    logic       sod = 1'b0;
    int         nbytes = 0;
    int         naborts = 0;
    int         errors = 0;
    int         num_checks = 0;

    fpw_host h (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
        .pause_n_o(pause_n), .wp_n_o(wp_n), .so_i(so), .so_oe_i(so_oe));

    fpw_ctrl #(.WAKE_CYCLES(WAKE)) dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .pause_n_i(pause_n), .wp_n_i(wp_n),
        .so_o(so), .so_oe_o(so_oe), .so_data_i(sod), .busy_i(busy),
        .standby_o(standby), .paused_o(paused), .write_enable_latch_o(write_enable_latch),
        .wp_active_o(wp_act), .busy_o(busy_o), .abort_o(abort),
        .byte_valid_o(bv), .byte_o(byte_o));

    // 10 MHz system clock
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // a hung handshake must still end the run with a verdict
    initial begin
        #3000000;
        errors++;
        results();
    end
    // record received bytes and abort pulses
    always @(negedge ref_clk_i) begin
        if (bv === 1'b1) begin
            nbytes <= nbytes + 1;
            last <= byte_o;
        end
        if (abort === 1'b1) naborts <= naborts + 1;
    end

    task automatic results;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic frame(input logic [15:0] d, input int n);
        h.pin(0, 1'b0);
        w(4);
        h.send(d, n, 1'b0);
        w(4);
        h.pin(0, 1'b1);
        w(12);
    endtask

    task automatic t_reset;
        chk_flag(standby, 1'b1);
        chk_flag(so_oe, 1'b0);
        h.pin(1, 1'b0);
        w(8);
        chk_flag(paused, 1'b0);
        h.pin(1, 1'b1);
        w(8);
    endtask
    task automatic t_wren;
        sod = 1'b1;
        frame(16'h0006, 8);
        chk_byte(last, 8'h06);
        chk_flag(write_enable_latch, 1'b1);
        chk_flag(h.so_cap_q, 1'b1);
    endtask
    // full-cycle transfer: host launches after a rise, samples at a fall
    task automatic t_full;
        sod = 1'b0;
        h.pin(0, 1'b0);
        w(4);
        h.send(16'h0006, 8, 1'b1);
        w(4);
        h.pin(0, 1'b1);
        w(12);
        chk_byte(last, 8'h06);
        chk_flag(h.so_cap_q, 1'b0);
        chk_flag(write_enable_latch, 1'b1);
    endtask
    // pause in mid-byte; clocks sent meanwhile must not count
    task automatic t_pause;
        h.pin(0, 1'b0);
        w(4);
        h.send(16'h0000, 3, 1'b0);
        h.pin(1, 1'b0);
        w(8);
        chk_flag(paused, 1'b1);
        chk_flag(so_oe, 1'b0);
        h.send(16'h001F, 5, 1'b0);
        chk_flag(paused, 1'b1);
        h.pin(2, 1'b0);
        busy = 1'b1;
        w(8);
        chk_flag(wp_act, 1'b1);
        chk_flag(busy_o, 1'b1);
        h.pin(2, 1'b1);
        busy = 1'b0;
        h.pin(1, 1'b1);
        w(8);
        chk_flag(paused, 1'b0);
        h.send(16'h0004, 5, 1'b0);
        w(4);
        h.pin(0, 1'b1);
        w(12);
        chk_byte(last, 8'h04);
        chk_flag(write_enable_latch, 1'b0);
    endtask
    // pause edges in the high phase wait for the next low phase
    task automatic t_defer;
        frame(16'h0006, 8);
        h.pin(0, 1'b0);
        w(4);
        h.send(16'h0000, 1, 1'b0);
        w(4);
        h.pin(3, 1'b1);
        w(4);
        h.pin(1, 1'b0);
        w(3);
        chk_flag(paused, 1'b0);
        h.pin(3, 1'b0);
        w(6);
        chk_flag(paused, 1'b1);
        h.pin(3, 1'b1);
        w(4);
        h.pin(1, 1'b1);
        w(3);
        chk_flag(paused, 1'b1);
        h.pin(3, 1'b0);
        w(6);
        chk_flag(paused, 1'b0);
        h.pin(1, 1'b0);
        w(6);
        h.pin(0, 1'b1);
        w(8);
        chk_byte(naborts[7:0], 8'h01);
        chk_flag(write_enable_latch, 1'b0);
        h.pin(1, 1'b1);
        w(8);
    endtask
    task automatic t_sleep_wake;
        int n;
        frame(16'h00B9, 8);
        chk_flag(standby, 1'b0);
        frame(16'h0006, 8);
        chk_flag(write_enable_latch, 1'b0);
        frame(16'h0055, 7);
        chk_flag(standby, 1'b0);
        frame(16'h0AB0, 12);
        chk_flag(standby, 1'b0);
        h.pin(0, 1'b0);
        w(4);
        h.send(16'hAB06, 16, 1'b0);
        w(4);
        h.pin(0, 1'b1);
        n = 0;
        while (standby !== 1'b1 && n < 100) begin
            w(1);
            n++;
        end
        chk_byte((n < WAKE + 8) ? 8'h01 : 8'h00, 8'h01);
        chk_flag(write_enable_latch, 1'b0);
        w(12);
        frame(16'h0006, 8);
        chk_flag(write_enable_latch, 1'b1);
    endtask

    // reset for four cycles, then the scenarios in turn
    initial begin
        rstn_i = 1'b0;
        busy = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        w(4);
        t_reset();
        t_wren();
        t_pause();
        t_full();
        t_defer();
        t_sleep_wake();
        results();
    end
endmodule // flash_serial_pause_wake_ctrl_bench
